//--- hw/pkw_regs.sv
/*
  Power key, wakeup pin, thermal and interrupt register bank of a
  power management chip, reached from a host over the two-wire link.
  Assumes all analogue comparators and pins are asynchronous levels.
*/
`timescale 1ns/1ps
module pkw_regs #(
  parameter int MS_CYCLES = pkw_pkg::MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic power_key_i,
  input wire logic wake_pin_i,
  output logic wake_pin_o,
  output logic wake_pin_oe_o,
  input wire logic [4:0] buck_uv_i,
  input wire logic [1:0] temp_over_i,
  input wire logic role_select_pin_i,
  output logic irq_o,
  output logic irq_oe_o,
  output logic power_on_o,
  output logic shutdown_o,
  output logic wakeup_o,
  output logic export_o,
  output logic temp_detect_en_o,
  output logic [1:0] temp_level_sel_o,
  output logic ref_save_en_o,
  output logic ref_cycle_o,
  output logic alt_serial_bus_o
);
  typedef struct packed {
    logic [2:0] key_sy;
    logic [2:0] wpin_sy;
    logic [1:0] role_sy;
    logic [2:0] req_sy;
    logic [4:0] uv_s1;
    logic [4:0] uv_s2;
    logic [4:0] uv_s3;
    logic [1:0] tmp_s1;
    logic [1:0] tmp_s2;
    logic [1:0] tmp_s3;
    logic ack_tgl;
    logic [7:0] rdata;
    logic [2:0] pwr_ctl;
    logic [3:0] wake_cfg;
    logic [7:0] key_cfg;
    logic [7:0] if_sel;
    logic [2:0] spc;
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] ref_cfg;
    logic [7:0] page;
    logic on;
    logic [13:0] tick;
    logic [13:0] hold;
    logic [6:0] ref_ms;
    logic ref_pulse;
    logic shut;
    logic wake;
    logic export_p;
    logic restart;
    logic wpo;
    logic wpe;
    logic irq;
  } pkw_core_s;
  pkw_core_s q, d;
  logic req_tgl;
  logic req_write;
  logic [7:0] req_addr;
  logic [7:0] req_wdata;
  logic ms_tick;
  logic pressed;
  logic press_edge;
  logic rel_edge;
  logic [1:0] t_over;
  logic [1:0] t_prev;
  logic wpin_lvl;
  logic wpin_prev;
  logic [7:0] ext;
  logic acc;
  logic sel;
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [6:0] ref_lim;
  // ----------------------------------------------------------------
  // host link
  // ----------------------------------------------------------------
  pkw_twi_link u_link (
    .link_clk_i(link_clk_i),
    .resetn_i(resetn_i),
    .scl_i(scl_i),
    .scl_o(scl_o),
    .scl_oe_o(scl_oe_o),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .req_tgl_o(req_tgl),
    .req_write_o(req_write),
    .req_addr_o(req_addr),
    .req_wdata_o(req_wdata),
    .ack_tgl_i(q.ack_tgl),
    .rdata_i(q.rdata)
  );
  function automatic logic hold_at(input logic tk,
                                   input logic [13:0] hold,
                                   input logic [13:0] lvl);
    hold_at = tk && (hold == lvl - 14'h0001);
  endfunction
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.key_sy = {q.key_sy[1:0], power_key_i};
    d.wpin_sy = {q.wpin_sy[1:0], wake_pin_i};
    d.role_sy = {q.role_sy[0], role_select_pin_i};
    d.req_sy = {q.req_sy[1:0], req_tgl};
    d.uv_s1 = buck_uv_i;
    d.uv_s2 = q.uv_s1;
    d.uv_s3 = q.uv_s2;
    d.tmp_s1 = temp_over_i;
    d.tmp_s2 = q.tmp_s1;
    d.tmp_s3 = q.tmp_s2;
    d.shut = 1'b0;
    d.wake = 1'b0;
    d.export_p = 1'b0;
    d.ref_pulse = 1'b0;
    d.restart = 1'b0;
    set1 = 8'h00;
    set2 = 8'h00;
    clr1 = 8'h00;
    clr2 = 8'h00;
    // millisecond time base
    ms_tick = (q.tick == 14'(MS_CYCLES - 1));
    d.tick = ms_tick ? 14'h0000 : q.tick + 14'h0001;
    // power key
    pressed = q.key_sy[1];
    press_edge = q.key_sy[1] & ~q.key_sy[2];
    rel_edge = ~q.key_sy[1] & q.key_sy[2];
    if (!pressed) begin
      d.hold = 14'h0000;
    end else if (ms_tick && q.hold != 14'h3FFF) begin
      d.hold = q.hold + 14'h0001;
    end
    set2[pkw_pkg::ST2_PRESS] = press_edge;
    set2[pkw_pkg::ST2_REL] = rel_edge;
    set2[pkw_pkg::ST2_SHORT] = rel_edge &&
      q.hold < pkw_pkg::LP_MS[q.key_cfg[5:4]];
    set2[pkw_pkg::ST2_LONG] = pressed &&
      hold_at(ms_tick, q.hold, pkw_pkg::LP_MS[q.key_cfg[5:4]]);
    if (pressed && q.on && q.key_cfg[pkw_pkg::KEY_OFF_EN] &&
        hold_at(ms_tick, q.hold, pkw_pkg::OFF_MS[q.key_cfg[1:0]])) begin
      d.shut = 1'b1;
      d.restart = q.key_cfg[pkw_pkg::KEY_AUTO_ON];
    end
    if (pressed && q.on && q.pwr_ctl[pkw_pkg::PWR_KEY16] &&
        hold_at(ms_tick, q.hold, pkw_pkg::KEY16_MS)) begin
      d.shut = 1'b1;
    end
    if (pressed && !q.on &&
        hold_at(ms_tick, q.hold, pkw_pkg::ON_MS[q.key_cfg[7:6]])) begin
      d.wake = 1'b1;
    end
    if (q.restart) begin
      d.wake = 1'b1;
    end
    // die temperature, gated by the detect enable
    t_over = q.tmp_s2 & {2{q.pwr_ctl[pkw_pkg::PWR_TDET]}};
    t_prev = q.tmp_s3 & {2{q.pwr_ctl[pkw_pkg::PWR_TDET]}};
    set1[1:0] = t_over & ~t_prev;
    clr1[1:0] = ~t_over;
    if (q.on && q.pwr_ctl[pkw_pkg::PWR_TSHUT] && t_over[1] &&
        !t_prev[1]) begin
      d.shut = 1'b1;
    end
    // buck undervoltage comparators
    set1[7:3] = q.uv_s2 & ~q.uv_s3;
    clr1[7:3] = ~q.uv_s2;
    // wakeup pin
    wpin_lvl = q.wpin_sy[1] == q.wake_cfg[pkw_pkg::WK_ACT];
    wpin_prev = q.wpin_sy[2] == q.wake_cfg[pkw_pkg::WK_ACT];
    if (q.wake_cfg[2:0] == pkw_pkg::WK_IN && wpin_lvl && !wpin_prev) begin
      set2[pkw_pkg::ST2_WPIN] = 1'b1;
      if (q.en2[pkw_pkg::ST2_WPIN] && !q.on) begin
        d.wake = 1'b1;
      end
    end
    case (q.wake_cfg[2:0])
      pkw_pkg::WK_OUT: begin
        d.wpe = 1'b1;
        d.wpo = q.on ~^ q.wake_cfg[pkw_pkg::WK_ACT];
      end
      pkw_pkg::WK_LOW: begin
        d.wpe = 1'b1;
        d.wpo = 1'b0;
      end
      pkw_pkg::WK_HIGH: begin
        d.wpe = 1'b1;
        d.wpo = 1'b1;
      end
      default: begin
        d.wpe = 1'b0;
        d.wpo = 1'b0;
      end
    endcase
    // self-clearing commands act one cycle after the write
    if (q.spc[pkw_pkg::SPC_OFF]) begin
      d.shut = 1'b1;
    end
    if (q.spc[pkw_pkg::SPC_WAKE]) begin
      d.wake = 1'b1;
    end
    d.export_p = q.spc[pkw_pkg::SPC_EXP];
    d.spc = 3'h0;
    // reference power saving
    ref_lim = 7'({3'({1'b0, q.ref_cfg[6:5]} + 3'h1), 4'h0} - 8'h01);
    if (q.ref_cfg[pkw_pkg::REF_SAVE] && q.on) begin
      if (ms_tick) begin
        if (q.ref_ms == ref_lim) begin
          d.ref_ms = 7'h00;
          d.ref_pulse = 1'b1;
        end else begin
          d.ref_ms = q.ref_ms + 7'h01;
        end
      end
    end else begin
      d.ref_ms = 7'h00;
    end
    // host access from the link domain
    ext = {2'h0, pkw_pkg::EXT_BIT1, ~q.role_sy[1], 4'h0};
    acc = q.req_sy[1] ^ q.req_sy[2];
    sel = req_addr == pkw_pkg::OFS_PAGE ||
          (q.page[7:4] == ext[7:4] && q.page[3:0] == 4'h0);
    if (acc) begin
      d.ack_tgl = ~q.ack_tgl;
      d.rdata = 8'h00;
      if (sel && !req_write) begin
        case (req_addr)
          pkw_pkg::OFS_PWR_CTL: d.rdata = {5'h00, q.pwr_ctl};
          pkw_pkg::OFS_WAKE_CFG: d.rdata = {4'h0, q.wake_cfg};
          pkw_pkg::OFS_KEY_CFG: d.rdata = q.key_cfg;
          pkw_pkg::OFS_IF_SEL: d.rdata = q.if_sel;
          pkw_pkg::OFS_SPC: d.rdata = {q.spc, 5'h00};
          pkw_pkg::OFS_EN1: d.rdata = q.en1;
          pkw_pkg::OFS_EN2: d.rdata = q.en2;
          pkw_pkg::OFS_ST1: d.rdata = q.st1;
          pkw_pkg::OFS_ST2: d.rdata = q.st2;
          pkw_pkg::OFS_REF: d.rdata = q.ref_cfg;
          pkw_pkg::OFS_EXT: d.rdata = ext;
          pkw_pkg::OFS_PAGE: d.rdata = q.page;
          default: d.rdata = 8'h00;
        endcase
      end
      if (sel && req_write) begin
        case (req_addr)
          pkw_pkg::OFS_PWR_CTL: d.pwr_ctl = req_wdata[2:0];
          pkw_pkg::OFS_WAKE_CFG: d.wake_cfg = req_wdata[3:0];
          pkw_pkg::OFS_KEY_CFG: d.key_cfg = req_wdata;
          pkw_pkg::OFS_IF_SEL: d.if_sel = req_wdata;
          pkw_pkg::OFS_SPC: d.spc = req_wdata[7:pkw_pkg::SPC_LSB];
          pkw_pkg::OFS_EN1: d.en1 = req_wdata & pkw_pkg::MASK_ST1;
          pkw_pkg::OFS_EN2: d.en2 = req_wdata & pkw_pkg::MASK_ST2;
          pkw_pkg::OFS_ST1: clr1 = clr1 | req_wdata;
          pkw_pkg::OFS_ST2: clr2 = req_wdata;
          pkw_pkg::OFS_REF: d.ref_cfg = req_wdata & pkw_pkg::MASK_REF;
          pkw_pkg::OFS_PAGE: d.page = req_wdata;
          default: begin
          end
        endcase
      end
    end
    // clear first, set last: an event in the clear cycle is kept
    d.st1 = ((q.st1 & ~clr1) | set1) & pkw_pkg::MASK_ST1;
    d.st2 = ((q.st2 & ~clr2) | set2) & pkw_pkg::MASK_ST2;
    // power state
    if (d.shut) begin
      d.on = 1'b0;
    end else if (d.wake) begin
      d.on = 1'b1;
    end
    d.irq = |(d.st1 & d.en1) | |(d.st2 & d.en2);
  end
  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{pwr_ctl: pkw_pkg::RST_PWR_CTL,
             wake_cfg: pkw_pkg::RST_WAKE_CFG,
             key_cfg: pkw_pkg::RST_KEY_CFG,
             if_sel: pkw_pkg::RST_IF_SEL,
             en1: pkw_pkg::RST_EN1,
             en2: pkw_pkg::RST_EN2,
             ref_cfg: pkw_pkg::RST_REF,
             page: pkw_pkg::RST_PAGE,
             on: 1'b1,
             default: '0};
    end else begin
      q <= d;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign irq_o = 1'b0;
  assign irq_oe_o = q.irq;
  assign power_on_o = q.on;
  assign shutdown_o = q.shut;
  assign wakeup_o = q.wake;
  assign export_o = q.export_p;
  assign wake_pin_o = q.wpo;
  assign wake_pin_oe_o = q.wpe;
  assign temp_detect_en_o = q.pwr_ctl[pkw_pkg::PWR_TDET];
  assign temp_level_sel_o = q.ref_cfg[1:0];
  assign ref_save_en_o = q.ref_cfg[pkw_pkg::REF_SAVE] & q.on;
  assign ref_cycle_o = q.ref_pulse;
  assign alt_serial_bus_o = q.if_sel == pkw_pkg::ALT_BUS_CODE;
endmodule

//--- inc/pkw_pkg.sv
/*
  Shared constants of the key, wakeup and interrupt register block:
  offsets, reset values, field positions and timing counts.
  Assumes a 10 MHz core clock and a slow two-wire host link.
*/
package pkw_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PWR_CTL = 8'h32;
  localparam logic [7:0] OFS_WAKE_CFG = 8'h35;
  localparam logic [7:0] OFS_KEY_CFG = 8'h36;
  localparam logic [7:0] OFS_IF_SEL = 8'h3E;
  localparam logic [7:0] OFS_SPC = 8'h3F;
  localparam logic [7:0] OFS_EN1 = 8'h40;
  localparam logic [7:0] OFS_EN2 = 8'h41;
  localparam logic [7:0] OFS_ST1 = 8'h48;
  localparam logic [7:0] OFS_ST2 = 8'h49;
  localparam logic [7:0] OFS_REF = 8'hF3;
  localparam logic [7:0] OFS_EXT = 8'hFE;
  localparam logic [7:0] OFS_PAGE = 8'hFF;
  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_PWR_CTL = 3'h6;
  localparam logic [3:0] RST_WAKE_CFG = 4'h0;
  localparam logic [7:0] RST_KEY_CFG = 8'h59;
  localparam logic [7:0] RST_IF_SEL = 8'h00;
  localparam logic [7:0] RST_EN1 = 8'h03;
  localparam logic [7:0] RST_EN2 = 8'h03;
  localparam logic [7:0] RST_REF = 8'h01;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] MASK_ST1 = 8'hFB;
  localparam logic [7:0] MASK_ST2 = 8'h73;
  localparam logic [7:0] MASK_REF = 8'hF3;
  localparam logic [7:0] ALT_BUS_CODE = 8'h7C;
  // arbitrary value for the customisable extended-address bit
  localparam logic EXT_BIT1 = 1'b0;
  // arbitrary two-wire device address
  localparam logic [6:0] TWI_ADDR = 7'h34;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PWR_TDET = 2;
  localparam int PWR_TSHUT = 1;
  localparam int PWR_KEY16 = 0;
  localparam int WK_ACT = 3;
  localparam int KEY_OFF_EN = 3;
  localparam int KEY_AUTO_ON = 2;
  localparam int SPC_LSB = 5;
  localparam int SPC_OFF = 2;
  localparam int SPC_EXP = 1;
  localparam int SPC_WAKE = 0;
  localparam int ST1_UV_LSB = 3;
  localparam int ST2_PRESS = 6;
  localparam int ST2_REL = 5;
  localparam int ST2_WPIN = 4;
  localparam int ST2_SHORT = 1;
  localparam int ST2_LONG = 0;
  localparam int REF_SAVE = 7;
  localparam logic [2:0] WK_IN = 3'h0;
  localparam logic [2:0] WK_OUT = 3'h1;
  localparam logic [2:0] WK_LOW = 3'h2;
  localparam logic [2:0] WK_HIGH = 3'h3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [13:0] KEY16_MS = 14'h3E80;
  localparam logic [13:0] ON_MS [0:3] =
    '{14'h0080, 14'h03E8, 14'h07D0, 14'h0BB8};
  localparam logic [13:0] LP_MS [0:3] =
    '{14'h03E8, 14'h05DC, 14'h07D0, 14'h09C4};
  localparam logic [13:0] OFF_MS [0:3] =
    '{14'h0FA0, 14'h1770, 14'h1F40, 14'h2710};
  localparam logic [3:0] REF_STEP_SHIFT = 4'h0;
endpackage

//--- hw/pkw_twi_link.sv
/*
  Two-wire serial slave on the link clock. Frames host accesses into
  one request at a time, toggle-signalled to the core clock domain.
  Assumes the core answers by toggling ack_tgl_i with rdata_i stable.
*/
`timescale 1ns/1ps
module pkw_twi_link (
  input wire logic link_clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic req_tgl_o,
  output logic req_write_o,
  output logic [7:0] req_addr_o,
  output logic [7:0] req_wdata_o,
  input wire logic ack_tgl_i,
  input wire logic [7:0] rdata_i
);
  typedef enum logic [6:0] {
    L_IDLE = 7'h01, L_ADDR = 7'h02, L_WR = 7'h04, L_ACK = 7'h08,
    L_HOLD = 7'h10, L_RD = 7'h20, L_ACKR = 7'h40
  } pkw_link_e;
  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic [2:0] ack_sy;
    pkw_link_e st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rw;
    logic first;
    logic busy;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic req;
    logic req_wr;
    logic sda_oe;
    logic scl_oe;
  } pkw_link_s;
  pkw_link_s q, d;
  logic rise, fall, start, stop;
  always_comb begin
    d = q;
    d.scl_sy = {q.scl_sy[1:0], scl_i};
    d.sda_sy = {q.sda_sy[1:0], sda_i};
    d.ack_sy = {q.ack_sy[1:0], ack_tgl_i};
    rise = q.scl_sy[1] & ~q.scl_sy[2];
    fall = ~q.scl_sy[1] & q.scl_sy[2];
    start = q.scl_sy[1] & q.scl_sy[2] & ~q.sda_sy[1] & q.sda_sy[2];
    stop = q.scl_sy[1] & q.scl_sy[2] & q.sda_sy[1] & ~q.sda_sy[2];
    if (q.busy && (q.ack_sy[1] ^ q.ack_sy[2])) begin
      d.busy = 1'b0;
      d.addr = q.addr + 8'h01;
      if (q.rw) begin
        d.sh = rdata_i;
      end
    end
    case (q.st)
      L_IDLE: begin
      end
      L_ADDR, L_WR: begin
        if (rise) begin
          d.sh = {q.sh[6:0], q.sda_sy[1]};
          d.cnt = q.cnt + 4'h1;
        end else if (fall && q.cnt == 4'h8) begin
          d.cnt = 4'h0;
          d.sda_oe = 1'b1;
          d.st = L_ACK;
          if (q.st == L_ADDR) begin
            d.rw = q.sh[0];
            if (q.sh[7:1] != pkw_pkg::TWI_ADDR) begin
              d.sda_oe = 1'b0;
              d.st = L_IDLE;
            end
          end else if (q.first) begin
            d.addr = q.sh;
            d.first = 1'b0;
          end else begin
            d.wdata = q.sh;
            d.req = ~q.req;
            d.req_wr = 1'b1;
            d.busy = 1'b1;
          end
        end
      end
      L_ACK: begin
        if (fall) begin
          d.sda_oe = 1'b0;
          d.scl_oe = 1'b1;
          d.st = L_HOLD;
          if (q.rw) begin
            d.req = ~q.req;
            d.req_wr = 1'b0;
            d.busy = 1'b1;
          end
        end
      end
      L_HOLD: begin
        // clock held low until the core has answered
        if (!q.busy) begin
          d.scl_oe = 1'b0;
          d.cnt = 4'h0;
          d.st = q.rw ? L_RD : L_WR;
          d.sda_oe = q.rw & ~q.sh[7];
        end
      end
      L_RD: begin
        if (fall) begin
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'h7) begin
            d.sda_oe = 1'b0;
            d.st = L_ACKR;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
          end
        end
      end
      L_ACKR: begin
        if (rise && q.sda_sy[1]) begin
          d.st = L_IDLE;
        end else if (fall) begin
          d.scl_oe = 1'b1;
          d.req = ~q.req;
          d.req_wr = 1'b0;
          d.busy = 1'b1;
          d.st = L_HOLD;
        end
      end
      default: d.st = L_IDLE;
    endcase
    if (start || stop) begin
      d.st = start ? L_ADDR : L_IDLE;
      d.cnt = 4'h0;
      d.first = 1'b1;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
    end
  end
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{scl_sy: 3'h7, sda_sy: 3'h7, st: L_IDLE, first: 1'b1,
             default: '0};
    end else begin
      q <= d;
    end
  end
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = q.scl_oe;
  assign sda_oe_o = q.sda_oe;
  assign req_tgl_o = q.req;
  assign req_write_o = q.req_wr;
  assign req_addr_o = q.addr;
  assign req_wdata_o = q.wdata;
endmodule

//--- dv/pkw_regs_chk.sv
/*
  Checker of the pulse, power and open-drain outputs of pkw_regs.
  Assumes the bind at the foot of this file.
*/
`timescale 1ns/1ps
module pkw_regs_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic irq_o,
  input wire logic sda_o,
  input wire logic scl_o,
  input wire logic power_on_o,
  input wire logic shutdown_o,
  input wire logic wakeup_o,
  input wire logic export_o,
  input wire logic ref_save_en_o,
  input wire logic ref_cycle_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_shut_pulse; shutdown_o |=> !shutdown_o; endproperty
  a_shut_pulse: assert property (p_shut_pulse)
    else $error("off pulse too long");
  property p_shut_off; shutdown_o |-> ##[0:1] !power_on_o; endproperty
  a_shut_off: assert property (p_shut_off)
    else $error("still on after off pulse");
  property p_off_cause;
    $fell(power_on_o) |-> shutdown_o || $past(shutdown_o);
  endproperty
  a_off_cause: assert property (p_off_cause)
    else $error("power dropped without off pulse");
  property p_wake_on; wakeup_o |-> ##[0:1] power_on_o; endproperty
  a_wake_on: assert property (p_wake_on)
    else $error("not on after wake pulse");
  property p_exp_pulse; export_o |=> !export_o; endproperty
  a_exp_pulse: assert property (p_exp_pulse)
    else $error("export pulse too long");
  property p_ref_gap; ref_cycle_o |=> !ref_cycle_o [*8]; endproperty
  a_ref_gap: assert property (p_ref_gap)
    else $error("reference pulses too close");
  property p_ref_on; ref_cycle_o |-> ref_save_en_o && power_on_o; endproperty
  a_ref_on: assert property (p_ref_on)
    else $error("reference cycled while not saving");
  property p_od_low; !irq_o && !sda_o && !scl_o; endproperty
  a_od_low: assert property (p_od_low)
    else $error("open-drain pin driven high");
  c_shut: cover property (shutdown_o);
  c_wake: cover property (wakeup_o);
  c_ref: cover property (ref_cycle_o);
endmodule
bind pkw_regs pkw_regs_chk pkw_regs_chk_i (.clk_i(clk_i),
  .resetn_i(resetn_i), .irq_o(irq_o), .sda_o(sda_o), .scl_o(scl_o),
  .power_on_o(power_on_o), .shutdown_o(shutdown_o), .wakeup_o(wakeup_o),
  .export_o(export_o), .ref_save_en_o(ref_save_en_o),
  .ref_cycle_o(ref_cycle_o));

//--- dv/pkw_host.sv
/*
  Two-wire host model; both lines pulled up.
  Assumes the slave pulls low through scl_oe_i and sda_oe_i.
*/
`timescale 1ns/1ps
module pkw_host (
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic scl_low = 1'h0;
  logic sda_low = 1'h0;
  assign scl_o = !(scl_low || scl_oe_i);
  assign sda_o = !(sda_low || sda_oe_i);
  // release clock, wait out a stretch
  task automatic hi();
    int n;
    n = 0;
    #250;
    scl_low = 1'h0;
    while (!scl_o && n < 2000) begin
      #10;
      n++;
    end
    #250;
  endtask
  // eight bits then a released ninth slot
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_low = (i > 0) && !d[i - 1];
      hi();
      if (i > 0) q[i - 1] = sda_o;
      scl_low = 1'h1;
      #100;
    end
  endtask
  task automatic beg();
    sda_low = 1'h1;
    #250;
    scl_low = 1'h1;
    #100;
  endtask
  task automatic fin();
    sda_low = 1'h1;
    hi();
    sda_low = 1'h0;
    #500;
  endtask
  // offset write; a read then restarts and takes one byte, nacked
  task automatic acc(input logic rd, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    beg();
    xfer({pkw_pkg::TWI_ADDR, 1'h0}, q);
    xfer(a, q);
    if (rd) begin
      fin();
      beg();
      xfer({pkw_pkg::TWI_ADDR, 1'h1}, q);
      d = 8'hFF;
    end
    xfer(d, q);
    fin();
  endtask
endmodule

//--- dv/pkw_regs_tb.sv
/*
  Self-checking bench of pkw_regs with short millisecond ticks.
  Assumes the pkw_host model and the bound checker.
*/
`timescale 1ns/1ps
module pkw_regs_tb;
  localparam int MS = 1;
  logic clk_i = 1'h0, link_clk_i = 1'h0, resetn_i = 1'h0;
  logic key = 1'h0, wk_i = 1'h1, role = 1'h1;
  logic [4:0] uv = 5'h00;
  logic [1:0] tmp = 2'h0, tlvl;
  logic scl, sda, scl_oe, sda_oe, wk_o, wk_oe, irq_oe, pon;
  logic shut, wake, expo, tden, rsave, rcyc, alt;
  logic [7:0] q;
  int n_mismatch = 0, check_count = 0;
  int cyc = 0, n_shut = 0, n_wake = 0, n_exp = 0;
  pkw_regs #(.MS_CYCLES(MS)) pkw_regs_i (.clk_i(clk_i),
    .resetn_i(resetn_i), .link_clk_i(link_clk_i), .scl_i(scl),
    .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .power_key_i(key), .wake_pin_i(wk_i),
    .wake_pin_o(wk_o), .wake_pin_oe_o(wk_oe), .buck_uv_i(uv),
    .temp_over_i(tmp), .role_select_pin_i(role), .irq_o(),
    .irq_oe_o(irq_oe), .power_on_o(pon), .shutdown_o(shut),
    .wakeup_o(wake), .export_o(expo), .temp_detect_en_o(tden),
    .temp_level_sel_o(tlvl), .ref_save_en_o(rsave),
    .ref_cycle_o(rcyc), .alt_serial_bus_o(alt));
  pkw_host pkw_host_i (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
    .scl_o(scl), .sda_o(sda));
  initial forever #50 clk_i = !clk_i;
  initial begin
    #3;
    forever #7.5 link_clk_i = !link_clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (shut) n_shut <= n_shut + 1;
    if (wake) n_wake <= n_wake + 1;
    if (expo) n_exp <= n_exp + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pkw_host_i.acc(1'h0, a, d, q);
    settle(2);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    pkw_host_i.acc(1'h1, a, 8'h00, q);
    settle(2);
    chk(16'(q), 16'(e));
  endtask
  task automatic t_reset();
    logic [7:0] a [10] = '{8'h40, 8'h41, 8'hF3, 8'h36, 8'h35, 8'h49,
                           8'h48, 8'h3F, 8'h3E, 8'hFE};
    logic [7:0] e [10] = '{8'h03, 8'h03, 8'h01, 8'h59, 8'h00, 8'h00,
                           8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) begin
      rd(a[i], e[i]);
    end
    chk(16'(tden), 16'h0001);
    chk(16'(tlvl), 16'h0001);
    $display("reset test done");
  endtask
  task automatic t_page();
    wr(8'hFF, 8'h10);
    rd(8'h40, 8'h00);
    wr(8'h40, 8'hFF);
    wr(8'hFF, 8'h01);
    rd(8'h40, 8'h00);
    wr(8'hFF, 8'h00);
    rd(8'h40, 8'h03);
    role <= 1'h0;
    settle(4);
    wr(8'hFF, 8'h10);
    rd(8'hFE, 8'h10);
    rd(8'h40, 8'h03);
    role <= 1'h1;
    wr(8'hFF, 8'h00);
    wr(8'h3E, 8'h7C);
    chk(16'(alt), 16'h0001);
    wr(8'h3E, 8'h00);
    chk(16'(alt), 16'h0000);
    $display("page test done");
  endtask
  task automatic t_cmd();
    wr(8'h3F, 8'h40);
    chk(16'(n_exp), 16'h0001);
    rd(8'h3F, 8'h00);
    wr(8'h3F, 8'h80);
    chk(16'(pon), 16'h0000);
    rd(8'h3F, 8'h00);
    wr(8'h3F, 8'h20);
    chk(16'(pon), 16'h0001);
    chk(16'(n_wake), 16'h0001);
    wr(8'h32, 8'h04);
    tmp <= 2'h3;
    settle(10);
    chk(16'(pon), 16'h0001);
    tmp <= 2'h0;
    wr(8'h32, 8'h06);
    tmp <= 2'h2;
    settle(10);
    chk(16'(n_shut), 16'h0002);
    tmp <= 2'h0;
    wr(8'h32, 8'h02);
    chk(16'(tden), 16'h0000);
    tmp <= 2'h3;
    settle(8);
    rd(8'h48, 8'h00);
    tmp <= 2'h0;
    wr(8'h32, 8'h06);
    wr(8'h3F, 8'h20);
    wr(8'h48, 8'h03);
    $display("command test done");
  endtask
  task automatic t_irq();
    tmp <= 2'h1;
    settle(8);
    rd(8'h48, 8'h01);
    chk(16'(irq_oe), 16'h0001);
    tmp <= 2'h0;
    settle(8);
    rd(8'h48, 8'h00);
    chk(16'(irq_oe), 16'h0000);
    uv <= 5'h01;
    settle(8);
    rd(8'h48, 8'h08);
    chk(16'(irq_oe), 16'h0000);
    wr(8'h40, 8'h0B);
    chk(16'(irq_oe), 16'h0001);
    wr(8'h48, 8'h08);
    rd(8'h48, 8'h00);
    uv <= 5'h00;
    wr(8'h40, 8'h03);
    wk_i <= 1'h0;
    settle(8);
    wk_i <= 1'h1;
    rd(8'h49, 8'h10);
    wr(8'h49, 8'h10);
    rd(8'h49, 8'h00);
    key <= 1'h1;
    settle(1000);
    key <= 1'h0;
    settle(8);
    rd(8'h49, 8'h62);
    chk(16'(irq_oe), 16'h0001);
    wr(8'h49, 8'h62);
    chk(16'(irq_oe), 16'h0000);
    $display("interrupt test done");
  endtask
  task automatic t_wake();
    logic [7:0] c [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h09, 8'h00};
    logic [1:0] e [6] = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h3, 2'h0};
    for (int i = 0; i < 6; i++) begin
      wr(8'h35, c[i]);
      chk(16'({wk_oe, wk_oe & wk_o}), 16'(e[i]));
    end
    $display("wake pin test done");
  endtask
  task automatic t_key();
    int s0, w0;
    s0 = n_shut;
    w0 = n_wake;
    wr(8'h36, 8'h4C);
    key <= 1'h1;
    settle(4100);
    key <= 1'h0;
    settle(8);
    chk(16'(n_shut - s0), 16'h0001);
    chk(16'(n_wake - w0), 16'h0001);
    chk(16'(pon), 16'h0001);
    rd(8'h49, 8'h61);
    wr(8'h49, 8'h61);
    wr(8'h36, 8'h40);
    wr(8'h32, 8'h07);
    key <= 1'h1;
    settle(16100);
    key <= 1'h0;
    settle(8);
    chk(16'(pon), 16'h0000);
    chk(16'(n_shut - s0), 16'h0002);
    wr(8'h3F, 8'h20);
    wr(8'h36, 8'h59);
    wr(8'h32, 8'h06);
    $display("key test done");
  endtask
  task automatic wait_ref();
    for (int n = 0; n < 3000 && rcyc !== 1'h1; n++) @(negedge clk_i);
  endtask
  task automatic gap(input logic [7:0] d, input int p);
    int t0;
    wr(8'hF3, d);
    wait_ref();
    t0 = cyc;
    @(negedge clk_i);
    wait_ref();
    chk(16'(cyc - t0), 16'(p));
  endtask
  task automatic t_ref();
    gap(8'h81, 16 * MS);
    chk(16'(rsave), 16'h0001);
    gap(8'hE3, 64 * MS);
    chk(16'(tlvl), 16'h0003);
    wr(8'hF3, 8'h01);
    chk(16'(rsave), 16'h0000);
    $display("reference test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    settle(3);
    resetn_i <= 1'h1;
    settle(5);
    t_reset();
    t_page();
    t_cmd();
    t_irq();
    t_key();
    t_wake();
    t_ref();
    end_sim();
  end
endmodule
